// >>> eeprom_byte_access_ctrl_tb.sv
// Self-checking bench for the byte access controller, driven by the CPU model.
// Assumes the package write time of 84480 core cycles, so one write fits the run.
`timescale 1ns/100ps
`default_nettype none
module eeprom_byte_access_ctrl_tb;
  import nvm_access_pkg::*;
  localparam int WR_CYC = WRITE_OSC_CYCLES * OSC_DIV_CYCLES;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic gie = 1'b0;
  logic pdn = 1'b0;
  logic [5:0] addr;
  logic wr, rd, stall, irq, keep;
  logic [7:0] wdat, rdat, v, a_w, d_w;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'h397f_d547;
  int cyc = 0;
  int n, t0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc++;
  nvm_cpu_model cpu (.i_clk(i_clk), .i_stall(stall), .i_rdata(rdat), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdat));
  nvm_byte_access_ctrl dut (.i_clk(i_clk), .i_srst(i_srst), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_wdata(wdat), .o_io_rdata(rdat), .o_cpu_stall(stall),
    .i_global_irq_enable(gie), .i_power_down_req(pdn), .o_ready_irq(irq),
    .o_osc_keep_alive(keep));
  // ****************************************
  // Checking
  // ****************************************
  function automatic logic [7:0] ctl(input logic [2:0] f);
    return {4'h0, f, 1'b0};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b000));
    cpu.put(ADDR_REG_OFFSET, 8'hff, n);
    cpu.get(ADDR_REG_OFFSET, v);
    chk8(v, 8'h7f);
    repeat (4) begin
      d_w = 8'($random(seed));
      cpu.put(DATA_REG_OFFSET, d_w, n);
      cpu.get(DATA_REG_OFFSET, v);
      chk8(v, d_w);
    end
    $display("register test done");
    cpu.put(CTRL_REG_OFFSET, 8'h02, n);
    chk8(8'(n), 8'h00);
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b000));
    cpu.put(CTRL_REG_OFFSET, 8'h04, n);
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b010));
    repeat (3) @(negedge i_clk);
    cpu.put(CTRL_REG_OFFSET, 8'h02, n);
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b000));
    $display("arm test done");
    a_w = 8'($random(seed)) & 8'h7f;
    d_w = 8'($random(seed));
    cpu.put(ADDR_REG_OFFSET, a_w, n);
    cpu.put(DATA_REG_OFFSET, d_w, n);
    cpu.put(CTRL_REG_OFFSET, 8'h04, n);
    cpu.put(CTRL_REG_OFFSET, 8'h0a, n);
    t0 = cyc;
    chk8(8'(n), 8'(WRITE_STALL_CYCLES));
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b101));
    gie = 1'b1;
    pdn = 1'b1;
    @(negedge i_clk);
    chk8({6'h0, irq, keep}, 8'h01);
    // Reset in mid-write must leave the write engine running
    i_srst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b001));
    cpu.put(CTRL_REG_OFFSET, 8'h08, n);
    while (v[1] === 1'b1 && cyc - t0 < WR_CYC + 200) cpu.get(CTRL_REG_OFFSET, v);
    chk8({7'h0, ((cyc - t0) inside {[WR_CYC - 25 : WR_CYC + 12]})}, 8'h01);
    chk8({6'h0, irq, keep}, 8'h02);
    pdn = 1'b0;
    gie = 1'b0;
    @(negedge i_clk);
    chk8({7'h0, irq}, 8'h00);
    $display("write test done");
    cpu.put(ADDR_REG_OFFSET, a_w, n);
    cpu.put(CTRL_REG_OFFSET, 8'h01, n);
    chk8(8'(n), 8'(READ_STALL_CYCLES));
    cpu.get(CTRL_REG_OFFSET, v);
    chk8(v, ctl(3'b000));
    cpu.get(DATA_REG_OFFSET, v);
    chk8(v, d_w);
    $display("read test done");
    wrap_up;
  end
  // Two write times of margin are not affordable; one write plus setup fits
  initial begin
    #(95_000 * 100);
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire

// >>> nvm_access_pkg.sv
// Constants for the byte-wide non-volatile data memory access block.
// Assumes a CPU I/O space with 6-bit register addresses and a 10 MHz core clock.
`default_nettype none
package nvm_access_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] ADDR_REG_OFFSET = 6'h1e;
  localparam logic [5:0] DATA_REG_OFFSET = 6'h1d;
  localparam logic [5:0] CTRL_REG_OFFSET = 6'h1c;
  localparam int READY_IRQ_ENABLE_BIT = 3;
  localparam int MASTER_WRITE_ARM_BIT = 2;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int READ_STROBE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
  localparam int WRITE_STALL_CYCLES = 2;
  localparam int READ_STALL_CYCLES = 4;
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int MEM_DEPTH = 128;
endpackage
`default_nettype wire

// >>> nvm_byte_access_ctrl.sv
// Byte access controller for a 128-byte non-volatile data memory.
// Assumes a CPU issuing one-cycle I/O strobes and honouring o_cpu_stall.
`timescale 1ns/100ps
`default_nettype none
module nvm_byte_access_ctrl
  import nvm_access_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [5:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_cpu_stall,
  input wire logic i_global_irq_enable,
  input wire logic i_power_down_req,
  output logic o_ready_irq,
  output logic o_osc_keep_alive
);
  typedef enum {IDLE, WRITING} wstate_type;

  logic [7:0] mem [MEM_DEPTH];
  logic [6:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic irq_en_ff, nxt_irq_en;
  logic arm_ff, nxt_arm;
  logic [2:0] arm_cnt_ff, nxt_arm_cnt;
  logic read_ff, nxt_read;
  logic [2:0] stall_ff, nxt_stall;
  wstate_type wstate_ff, nxt_wstate;
  logic [13:0] wcnt_ff, nxt_wcnt;
  logic [6:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic osc_tick;
  logic wr_ctrl, wr_addr, wr_data, start_write, start_read, write_done;
  logic [16:0] wr_len_ff, nxt_wr_len;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  assign wr_ctrl = i_io_wr && hit(i_io_addr, CTRL_REG_OFFSET);
  assign wr_addr = i_io_wr && hit(i_io_addr, ADDR_REG_OFFSET);
  assign wr_data = i_io_wr && hit(i_io_addr, DATA_REG_OFFSET);
  assign start_write = wr_ctrl && i_io_wdata[WRITE_STROBE_BIT] && arm_ff && !i_srst
    && wstate_ff == IDLE;
  assign start_read = wr_ctrl && i_io_wdata[READ_STROBE_BIT] && !i_srst && !start_write;
  assign write_done = wstate_ff == WRITING && osc_tick
    && wcnt_ff == 14'(WRITE_OSC_CYCLES - 1);

  nvm_osc_tick u_osc_tick (
    .i_clk(i_clk),
    .i_run(wstate_ff == WRITING),
    .o_tick(osc_tick)
  );

  // ****************************************
  // Register file and strobes
  // ****************************************
  always_comb begin
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_irq_en = irq_en_ff;
    nxt_arm = arm_ff;
    nxt_arm_cnt = arm_cnt_ff;
    nxt_read = 1'b0;
    nxt_stall = (stall_ff != 3'h0) ? stall_ff - 3'h1 : 3'h0;
    if (arm_ff) begin
      nxt_arm_cnt = arm_cnt_ff + 3'h1;
      if (arm_cnt_ff == 3'(ARM_WINDOW_CYCLES - 1)) begin
        nxt_arm = 1'b0;
      end
    end
    if (wr_addr) begin
      nxt_addr = i_io_wdata[6:0];
    end
    if (wr_data) begin
      nxt_data = i_io_wdata;
    end
    if (wr_ctrl) begin
      nxt_irq_en = i_io_wdata[READY_IRQ_ENABLE_BIT];
      if (i_io_wdata[MASTER_WRITE_ARM_BIT]) begin
        nxt_arm = 1'b1;
        nxt_arm_cnt = 3'h0;
      end
    end
    if (start_write) begin
      nxt_stall = 3'(WRITE_STALL_CYCLES);
      nxt_arm = 1'b0;
    end
    if (start_read) begin
      nxt_read = 1'b1;
      nxt_data = mem[addr_ff];
      nxt_stall = 3'(READ_STALL_CYCLES);
    end
    if (i_srst) begin
      nxt_irq_en = CTRL_RESET[READY_IRQ_ENABLE_BIT];
      nxt_arm = 1'b0;
      nxt_arm_cnt = 3'h0;
      nxt_read = 1'b0;
      nxt_stall = 3'h0;
      nxt_data = DATA_RESET;
      nxt_addr = ADDR_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    addr_ff <= nxt_addr;
    data_ff <= nxt_data;
    irq_en_ff <= nxt_irq_en;
    arm_ff <= nxt_arm;
    arm_cnt_ff <= nxt_arm_cnt;
    read_ff <= nxt_read;
    stall_ff <= nxt_stall;
  end

  // ****************************************
  // Self-timed write engine
  // ****************************************
  // Not reset on purpose: a write in flight must finish
  always_comb begin
    nxt_wstate = wstate_ff;
    nxt_wcnt = wcnt_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    case (wstate_ff)
      IDLE: begin
        if (start_write) begin
          nxt_wstate = WRITING;
          nxt_wcnt = 14'h0;
          nxt_waddr = addr_ff;
          nxt_wdata = data_ff;
        end
      end
      WRITING: begin
        if (osc_tick) begin
          nxt_wcnt = wcnt_ff + 14'h1;
        end
        if (write_done) begin
          nxt_wstate = IDLE;
        end
      end
      default: nxt_wstate = IDLE;
    endcase
  end

  // Two-state enum wakes up in IDLE, so no reset is needed to start clean

  always_ff @(posedge i_clk) begin
    wstate_ff <= nxt_wstate;
    wcnt_ff <= nxt_wcnt;
    waddr_ff <= nxt_waddr;
    wdata_ff <= nxt_wdata;
    if (write_done) begin
      mem[waddr_ff] <= wdata_ff;
    end
  end

  // ****************************************
  // Read back and outputs
  // ****************************************
  always_comb begin
    o_io_rdata = 8'h00;
    // Bus stays at zero outside a read cycle
    if (!i_io_rd) begin
      o_io_rdata = 8'h00;
    end else if (hit(i_io_addr, ADDR_REG_OFFSET)) begin
      o_io_rdata = {1'b0, addr_ff};
    end else if (hit(i_io_addr, DATA_REG_OFFSET)) begin
      o_io_rdata = data_ff;
    end else if (hit(i_io_addr, CTRL_REG_OFFSET)) begin
      o_io_rdata = {4'h0, irq_en_ff, arm_ff, wstate_ff == WRITING, read_ff};
    end
  end

  assign o_cpu_stall = stall_ff != 3'h0;
  assign o_ready_irq = irq_en_ff && i_global_irq_enable && wstate_ff == IDLE;
  assign o_osc_keep_alive = (wstate_ff == WRITING) && i_power_down_req;

  // ****************************************
  // Checks
  // ****************************************
  // Core cycles spent writing, for the length check only
  always_comb begin
    nxt_wr_len = wr_len_ff;
    if (start_write) begin
      nxt_wr_len = 17'h0;
    end else if (wstate_ff == WRITING) begin
      nxt_wr_len = wr_len_ff + 17'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    wr_len_ff <= nxt_wr_len;
  end

  a_write_stall: assert property (@(posedge i_clk) disable iff (i_srst)
    start_write |=> o_cpu_stall [*2] ##1 !o_cpu_stall) else $error("write stall wrong");
  a_read_stall: assert property (@(posedge i_clk) disable iff (i_srst)
    start_read |=> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read stall wrong");
  a_arm_expiry: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_ctrl && i_io_wdata[MASTER_WRITE_ARM_BIT] && !start_write)
    ##1 (!wr_ctrl) [*4] |=> !arm_ff) else $error("arm did not expire");
  a_arm_needed: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_ctrl && i_io_wdata[WRITE_STROBE_BIT] && !arm_ff && wstate_ff == IDLE)
    |=> wstate_ff == IDLE) else $error("unarmed write started");
  a_write_busy: assert property (@(posedge i_clk)
    start_write |=> (wstate_ff == WRITING) [*8]) else $error("write ended early");
  a_ready_level: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_ff && i_global_irq_enable) |-> (o_ready_irq == (wstate_ff != WRITING)))
    else $error("ready irq wrong");
  a_read_data: assert property (@(posedge i_clk) disable iff (i_srst)
    start_read |=> data_ff == mem[$past(addr_ff)]) else $error("read data wrong");
  a_addr_top: assert property (@(posedge i_clk)
    hit(i_io_addr, ADDR_REG_OFFSET) |-> !o_io_rdata[7]) else $error("addr top bit set");
  a_write_length: assert property (@(posedge i_clk)
    write_done |-> wr_len_ff == 17'(WRITE_OSC_CYCLES * OSC_DIV_CYCLES - 1))
    else $error("write length wrong");
  a_read_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    start_read |=> read_ff ##1 !read_ff) else $error("read strobe not cleared");
  c_write: cover property (@(posedge i_clk) start_write);
  c_read: cover property (@(posedge i_clk) start_read);
  c_done: cover property (@(posedge i_clk) write_done);
  c_reset_mid_write: cover property (@(posedge i_clk) i_srst && wstate_ff == WRITING);
endmodule
`default_nettype wire

// >>> nvm_cpu_model.sv
// CPU-side model: one-cycle I/O register writes that honour the stall, and one-cycle reads that do not wait on it.
// Assumes the controller raises its stall output at the edge that takes an access.
`timescale 1ns/100ps
`default_nettype none
module nvm_cpu_model (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic [7:0] i_rdata,
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial begin
    o_addr = 6'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // ****************************************
  // Accesses
  // ****************************************
  // Returns the cycles spent halted after the access
  task automatic put(input logic [5:0] a, input logic [7:0] d, output int n);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released data must not keep looking valid
    o_wdata = ~d;
    n = 0;
    while (i_stall) begin
      n++;
      @(negedge i_clk);
    end
  endtask
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    d = i_rdata;
    @(negedge i_clk);
    o_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> nvm_osc_tick.sv
// Divider giving a one-cycle pulse at the 1 MHz self-timing rate.
// Assumes the core clock is an integer multiple of that rate.
`timescale 1ns/100ps
`default_nettype none
module nvm_osc_tick
  import nvm_access_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_tick
);
  logic [3:0] div_ff;
  logic [3:0] nxt_div;

  // Not reset: the divider belongs to the write timer, which survives reset
  always_comb begin
    nxt_div = 4'h0;
    if (i_run && div_ff != 4'(OSC_DIV_CYCLES - 1)) begin
      nxt_div = div_ff + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    div_ff <= nxt_div;
  end

  assign o_tick = i_run && (div_ff == 4'(OSC_DIV_CYCLES - 1));
endmodule
`default_nettype wire
